// [rtl/core_pkg.sv]
// Purpose: shared constants and types for the instruction timing core
// Assumes: 16-bit instruction words, 8-bit data path, 8-bit program counter
// Notes:   instruction word = {op, sel, arg}; sel is bit index, dest select or system code
package core_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_PS    = 25000;
    localparam int unsigned CLKS_PER_ICYCLE  = 4;

    // ------------------------------------------------------------
    // data memory map and stack depth
    // ------------------------------------------------------------
    localparam logic [7:0] PCL_ADDR          = 8'h02;
    localparam int unsigned STACK_DEPTH      = 4;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  PC_RESET         = 8'h00;
    localparam logic [7:0]  ACC_RESET        = 8'h00;
    localparam logic [15:0] IR_RESET         = 16'h0000;

    // ------------------------------------------------------------
    // field positions and system codes inside sel
    // ------------------------------------------------------------
    localparam int unsigned SEL_DEST_ACC_BIT = 0;
    localparam logic [2:0]  SYS_POWER_DOWN   = 3'h0;
    localparam logic [2:0]  SYS_WDT_CLEAR    = 3'h1;

    typedef enum logic [1:0] {
        PH_FETCH  = 2'b00,
        PH_DECODE = 2'b01,
        PH_READ   = 2'b10,
        PH_EXEC   = 2'b11
    } phase_t;

    typedef enum logic [4:0] {
        OP_NOP   = 5'b00000, OP_ADD   = 5'b00001, OP_SUB   = 5'b00010,
        OP_AND   = 5'b00011, OP_OR    = 5'b00100, OP_XOR   = 5'b00101,
        OP_INV   = 5'b00110, OP_INC   = 5'b00111, OP_DEC   = 5'b01000,
        OP_RR    = 5'b01001, OP_RL    = 5'b01010, OP_RRC   = 5'b01011,
        OP_RLC   = 5'b01100, OP_MOVM  = 5'b01101, OP_MOVMA = 5'b01110,
        OP_MOVI  = 5'b01111, OP_CLRM  = 5'b10000, OP_BCLR  = 5'b10001,
        OP_BSET  = 5'b10010, OP_JUMP  = 5'b10011, OP_CALL  = 5'b10100,
        OP_RET   = 5'b10101, OP_INTERRUPT_EXIT  = 5'b10110, OP_SZ    = 5'b10111,
        OP_SNZ   = 5'b11000, OP_SZB   = 5'b11001, OP_SNZB  = 5'b11010,
        OP_TBLRD = 5'b11011, OP_SYS   = 5'b11100
    } op_t;

    typedef struct packed {
        op_t        op;
        logic [2:0] sel;
        logic [7:0] arg;
    } instr_t;

endpackage : core_pkg

// [rtl/instr_timing_core.sv]
// Purpose: instruction sequencing, timing and execution of an 8-bit core
// Assumes: memories answer within one clock of a new address
// Notes:   one instruction cycle = four clocks: fetch, decode, read, execute
`timescale 1ns/1ps
module instr_timing_core
    import core_pkg::*;
(
    input  wire logic        CLK_SYS,
    input  wire logic        RESETN,
    input  wire logic [15:0] PMEM_RDATA,
    input  wire logic [7:0]  DMEM_RDATA,
    input  wire logic        WAKE,
    output logic      [7:0]  PMEM_ADDR,
    output logic      [7:0]  DMEM_ADDR,
    output logic      [7:0]  DMEM_WDATA,
    output logic             DMEM_WE,
    output logic      [7:0]  ACC,
    output logic             CARRY,
    output logic             ZERO,
    output logic             HALTED,
    output logic             WDT_CLEAR,
    output logic             INSTR_DONE,
    output logic             EXTRA_CYCLE
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    phase_t      phase_ff,     nxt_phase;
    instr_t      ir_ff,        nxt_ir;
    logic [7:0]  pc_ff,        nxt_pc;
    logic [7:0]  acc_ff,       nxt_acc;
    logic [7:0]  pmem_addr_ff, nxt_pmem_addr;
    logic [7:0]  dmem_addr_ff, nxt_dmem_addr;
    logic [7:0]  wdata_ff,     nxt_wdata;
    logic        we_ff,        nxt_we;
    logic        carry_ff,     nxt_carry;
    logic        zero_ff,      nxt_zero;
    logic        extra_ff,     nxt_extra;
    logic        tbl_ff,       nxt_tbl;
    logic        halted_ff,    nxt_halted;
    logic        wdt_ff,       nxt_wdt;
    logic        done_ff,      nxt_done;
    logic [1:0]  sp_ff,        nxt_sp;
    logic [7:0]  stack_ff      [STACK_DEPTH];
    logic [7:0]  nxt_stack     [STACK_DEPTH];

    logic        live_exec;
    logic [7:0]  mval;

    // the low program counter byte is not in data memory; reads see pc
    assign mval      = (ir_ff.arg == PCL_ADDR) ? pc_ff : DMEM_RDATA;
    assign live_exec = (phase_ff == PH_EXEC) && !extra_ff && !halted_ff;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic [8:0] wide;
        logic [7:0] res;
        logic [7:0] new_pc;
        logic       wr;
        logic       to_mem;
        logic       jump;
        logic       skip;
        wide          = 9'h000;
        res           = 8'h00;
        new_pc        = 8'(pc_ff + 8'h01);
        wr            = 1'b0;
        to_mem        = !ir_ff.sel[SEL_DEST_ACC_BIT];
        jump          = 1'b0;
        skip          = 1'b0;
        nxt_phase     = phase_t'(phase_ff + 2'h1);
        nxt_ir        = ir_ff;
        nxt_pc        = pc_ff;
        nxt_acc       = acc_ff;
        nxt_pmem_addr = pmem_addr_ff;
        nxt_dmem_addr = dmem_addr_ff;
        nxt_wdata     = wdata_ff;
        nxt_we        = 1'b0;
        nxt_carry     = carry_ff;
        nxt_zero      = zero_ff;
        nxt_extra     = extra_ff;
        nxt_tbl       = tbl_ff;
        nxt_halted    = halted_ff;
        nxt_wdt       = 1'b0;
        nxt_done      = 1'b0;
        nxt_sp        = sp_ff;
        nxt_stack     = stack_ff;
        case (phase_ff)
            PH_DECODE:
            begin
                if (extra_ff)
                begin
                    if (tbl_ff)
                        nxt_acc = PMEM_RDATA[7:0];
                end
                else if (!halted_ff)
                begin
                    // prefetch slot is dead while an extra cycle runs
                    nxt_ir        = instr_t'(PMEM_RDATA);
                    nxt_dmem_addr = PMEM_RDATA[7:0];
                end
            end
            PH_EXEC:
            begin
                if (extra_ff)
                begin
                    nxt_extra     = 1'b0;
                    nxt_tbl       = 1'b0;
                    nxt_pmem_addr = pc_ff;
                    nxt_done      = 1'b1;
                end
                else if (halted_ff)
                begin
                    if (WAKE)
                        nxt_halted = 1'b0;
                end
                else
                begin
                    case (ir_ff.op)
                        OP_ADD:
                        begin
                            wide      = {1'b0, acc_ff} + {1'b0, mval};
                            res       = wide[7:0];
                            nxt_carry = wide[8];
                            wr        = 1'b1;
                        end
                        OP_SUB:
                        begin
                            wide      = {1'b0, acc_ff} - {1'b0, mval};
                            res       = wide[7:0];
                            nxt_carry = !wide[8];
                            wr        = 1'b1;
                        end
                        OP_AND:  begin res = acc_ff & mval; wr = 1'b1; end
                        OP_OR:   begin res = acc_ff | mval; wr = 1'b1; end
                        OP_XOR:  begin res = acc_ff ^ mval; wr = 1'b1; end
                        OP_INV:  begin res = ~mval; wr = 1'b1; end
                        OP_INC:  begin res = 8'(mval + 8'h01); wr = 1'b1; end
                        OP_DEC:  begin res = 8'(mval - 8'h01); wr = 1'b1; end
                        OP_RR:   begin res = {mval[0], mval[7:1]}; wr = 1'b1; end
                        OP_RL:   begin res = {mval[6:0], mval[7]}; wr = 1'b1; end
                        OP_RRC:
                        begin
                            res       = {carry_ff, mval[7:1]};
                            nxt_carry = mval[0];
                            wr        = 1'b1;
                        end
                        OP_RLC:
                        begin
                            res       = {mval[6:0], carry_ff};
                            nxt_carry = mval[7];
                            wr        = 1'b1;
                        end
                        OP_MOVM: begin res = mval; wr = 1'b1; end
                        OP_MOVMA: begin res = acc_ff; wr = 1'b1; to_mem = 1'b1; end
                        OP_MOVI:  nxt_acc = ir_ff.arg;
                        OP_CLRM:  begin res = 8'h00; wr = 1'b1; to_mem = 1'b1; end
                        OP_BCLR, OP_BSET:
                        begin
                            // read-modify-write done here so other bits survive
                            res              = mval;
                            res[ir_ff.sel]   = (ir_ff.op == OP_BSET);
                            wr               = 1'b1;
                            to_mem           = 1'b1;
                        end
                        OP_JUMP:
                        begin
                            new_pc = ir_ff.arg;
                            jump   = 1'b1;
                        end
                        OP_CALL:
                        begin
                            // stack wraps silently past its depth
                            nxt_stack[sp_ff] = new_pc;
                            nxt_sp           = 2'(sp_ff + 2'h1);
                            new_pc           = ir_ff.arg;
                            jump             = 1'b1;
                        end
                        OP_RET, OP_INTERRUPT_EXIT:
                        begin
                            nxt_sp = 2'(sp_ff - 2'h1);
                            new_pc = stack_ff[2'(sp_ff - 2'h1)];
                            jump   = 1'b1;
                        end
                        OP_SZ, OP_SNZ:
                        begin
                            skip = (mval == 8'h00) ^ (ir_ff.op == OP_SNZ);
                            if (ir_ff.sel[SEL_DEST_ACC_BIT])
                                nxt_acc = mval;
                        end
                        OP_SZB:  skip = !mval[ir_ff.sel];
                        OP_SNZB: skip = mval[ir_ff.sel];
                        OP_TBLRD:
                        begin
                            nxt_tbl   = 1'b1;
                            nxt_extra = 1'b1;
                        end
                        OP_SYS:
                        begin
                            nxt_halted = (ir_ff.sel == SYS_POWER_DOWN);
                            nxt_wdt    = (ir_ff.sel == SYS_WDT_CLEAR);
                        end
                        default: ;
                    endcase
                    if (wr && to_mem && (ir_ff.arg == PCL_ADDR))
                    begin
                        new_pc = res;
                        jump   = 1'b1;
                    end
                    else if (wr && to_mem)
                    begin
                        nxt_we    = 1'b1;
                        nxt_wdata = res;
                    end
                    else if (wr)
                        nxt_acc = res;
                    if (wr && (ir_ff.op inside {OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR,
                                                OP_INV, OP_INC, OP_DEC}))
                        nxt_zero = (res == 8'h00);
                    if (skip)
                        new_pc = 8'(pc_ff + 8'h02);
                    if (jump || skip)
                        nxt_extra = 1'b1;
                    nxt_pc        = new_pc;
                    nxt_pmem_addr = (ir_ff.op == OP_TBLRD) ? mval : new_pc;
                    nxt_done      = !(jump || skip || ir_ff.op == OP_TBLRD);
                end
            end
            default: ;
        endcase
    end

    always_ff @(posedge CLK_SYS or negedge RESETN)
    begin
        if (!RESETN)
        begin
            phase_ff     <= PH_FETCH;
            ir_ff        <= instr_t'(IR_RESET);
            pc_ff        <= PC_RESET;
            acc_ff       <= ACC_RESET;
            pmem_addr_ff <= PC_RESET;
            dmem_addr_ff <= 8'h00;
            wdata_ff     <= 8'h00;
            we_ff        <= 1'b0;
            carry_ff     <= 1'b0;
            zero_ff      <= 1'b0;
            extra_ff     <= 1'b0;
            tbl_ff       <= 1'b0;
            halted_ff    <= 1'b0;
            wdt_ff       <= 1'b0;
            done_ff      <= 1'b0;
            sp_ff        <= 2'h0;
            for (int i = 0; i < STACK_DEPTH; i++)
                stack_ff[i] <= 8'h00;
        end
        else
        begin
            phase_ff     <= nxt_phase;
            ir_ff        <= nxt_ir;
            pc_ff        <= nxt_pc;
            acc_ff       <= nxt_acc;
            pmem_addr_ff <= nxt_pmem_addr;
            dmem_addr_ff <= nxt_dmem_addr;
            wdata_ff     <= nxt_wdata;
            we_ff        <= nxt_we;
            carry_ff     <= nxt_carry;
            zero_ff      <= nxt_zero;
            extra_ff     <= nxt_extra;
            tbl_ff       <= nxt_tbl;
            halted_ff    <= nxt_halted;
            wdt_ff       <= nxt_wdt;
            done_ff      <= nxt_done;
            sp_ff        <= nxt_sp;
            stack_ff     <= nxt_stack;
        end
    end

    assign PMEM_ADDR   = pmem_addr_ff;
    assign DMEM_ADDR   = dmem_addr_ff;
    assign DMEM_WDATA  = wdata_ff;
    assign DMEM_WE     = we_ff;
    assign ACC         = acc_ff;
    assign CARRY       = carry_ff;
    assign ZERO        = zero_ff;
    assign HALTED      = halted_ff;
    assign WDT_CLEAR   = wdt_ff;
    assign INSTR_DONE  = done_ff;
    assign EXTRA_CYCLE = extra_ff;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RESETN);

    logic plain_arg;
    assign plain_arg = (ir_ff.arg != PCL_ADDR);

    chk_phase_cycle: assert property (
        phase_ff == PH_EXEC |=> phase_ff == PH_FETCH ##3 phase_ff == PH_EXEC)
        else $error("instruction cycle is not four clocks");
    chk_done_spacing: assert property (
        INSTR_DONE |=> !INSTR_DONE [*3])
        else $error("instructions completed closer than four clocks");
    chk_single_cycle: assert property (
        live_exec && ir_ff.op == OP_AND && plain_arg |=> INSTR_DONE && !EXTRA_CYCLE)
        else $error("logic op did not finish in one cycle");
    chk_jump_extra: assert property (
        live_exec && ir_ff.op == OP_JUMP
        |=> EXTRA_CYCLE && PMEM_ADDR == ir_ff.arg ##0 !INSTR_DONE [*4] ##1 INSTR_DONE)
        else $error("jump timing or target wrong");
    chk_pcl_write: assert property (
        live_exec && ir_ff.op == OP_MOVMA && !plain_arg
        |=> EXTRA_CYCLE && !DMEM_WE && pc_ff == $past(acc_ff))
        else $error("program counter write did not jump");
    chk_skip_taken: assert property (
        live_exec && ir_ff.op == OP_SZ && plain_arg && DMEM_RDATA == 8'h00
        |=> EXTRA_CYCLE && pc_ff == 8'($past(pc_ff) + 8'h02))
        else $error("taken skip wrong");
    chk_add_carry: assert property (
        live_exec && ir_ff.op == OP_ADD && plain_arg
        |=> CARRY == (({1'b0, $past(acc_ff)} + {1'b0, $past(DMEM_RDATA)}) > 9'h0FF))
        else $error("add carry wrong");
    chk_inc_one: assert property (
        live_exec && ir_ff.op == OP_INC && plain_arg
        |=> (ir_ff.sel[0] ? ACC : DMEM_WDATA) == 8'($past(DMEM_RDATA) + 8'h01)
            && ZERO == (8'($past(DMEM_RDATA) + 8'h01) == 8'h00))
        else $error("increment result wrong");
    chk_return_addr: assert property (
        live_exec && ir_ff.op == OP_RET |=> pc_ff == $past(stack_ff[2'(sp_ff - 2'h1)]))
        else $error("return address wrong");
    chk_bit_set: assert property (
        live_exec && ir_ff.op == OP_BSET && plain_arg
        |=> DMEM_WE && DMEM_WDATA == ($past(DMEM_RDATA) | (8'h01 << $past(ir_ff.sel))))
        else $error("bit set disturbed other bits");
    chk_table_read: assert property (
        live_exec && ir_ff.op == OP_TBLRD && plain_arg
        |=> PMEM_ADDR == $past(DMEM_RDATA) ##2 ACC == $past(PMEM_RDATA[7:0]))
        else $error("table read wrong");
    chk_halt_entry: assert property (
        live_exec && ir_ff.op == OP_SYS && ir_ff.sel == SYS_POWER_DOWN |=> HALTED)
        else $error("power-down not entered");
    chk_hold_off: assert property (
        EXTRA_CYCLE && phase_ff == PH_DECODE |=> ir_ff == $past(ir_ff))
        else $error("fetch during extra cycle");

    cov_call: cover property (live_exec && ir_ff.op == OP_CALL);
    cov_skip: cover property (live_exec && ir_ff.op == OP_SNZB ##1 EXTRA_CYCLE);
    cov_table: cover property (live_exec && ir_ff.op == OP_TBLRD);
    cov_wake: cover property (HALTED ##1 !HALTED);

endmodule : instr_timing_core

// [tb/core_mem_model.sv]
// Purpose: program and data memory on the far side of the core
// Assumes: read data follows the address at once; writes land on the rising edge
// Notes:   the bench preloads both arrays by hierarchical reference
`timescale 1ns/1ps
module core_mem_model
(
    input  wire logic        clk,
    input  wire logic [7:0]  pmem_addr,
    input  wire logic [7:0]  dmem_addr,
    input  wire logic [7:0]  dmem_wdata,
    input  wire logic        dmem_we,
    output logic      [15:0] pmem_rdata,
    output logic      [7:0]  dmem_rdata
);
    logic [15:0] pmem [256];
    logic [7:0]  dmem [256];

    // plain always, not always_ff: the bench also preloads dmem
    assign pmem_rdata = pmem[pmem_addr];
    assign dmem_rdata = dmem[dmem_addr];
    always @(posedge clk)
    begin
        if (dmem_we === 1'b1)
        begin
            dmem[dmem_addr] <= dmem_wdata;
        end
    end
endmodule : core_mem_model

// [tb/mcu_instruction_timing_control_tb_top.sv]
// Purpose: self-checking bench for the instruction timing core
// Assumes: memory model answers at once; programs loaded while reset is held
// Notes:   clocks per instruction counted between done pulses at falling edges
`timescale 1ns/1ps
module mcu_instruction_timing_control_tb_top
    import core_pkg::*;
;
    logic        clk_sys, resetn, wake, wdt_seen;
    logic [15:0] pmem_rdata;
    logic [7:0]  dmem_rdata, pmem_addr, dmem_addr, dmem_wdata, acc;
    logic        dmem_we, carry, zero, halted, wdt_clear, instr_done, extra_cycle;
    int          n_errors = 0;
    int          checks_done = 0;

    instr_timing_core i_dut (.CLK_SYS(clk_sys), .RESETN(resetn), .PMEM_RDATA(pmem_rdata),
        .DMEM_RDATA(dmem_rdata), .WAKE(wake), .PMEM_ADDR(pmem_addr), .DMEM_ADDR(dmem_addr),
        .DMEM_WDATA(dmem_wdata), .DMEM_WE(dmem_we), .ACC(acc), .CARRY(carry), .ZERO(zero),
        .HALTED(halted), .WDT_CLEAR(wdt_clear), .INSTR_DONE(instr_done),
        .EXTRA_CYCLE(extra_cycle));
    core_mem_model i_mem (.clk(clk_sys), .pmem_addr(pmem_addr), .dmem_addr(dmem_addr),
        .dmem_wdata(dmem_wdata), .dmem_we(dmem_we), .pmem_rdata(pmem_rdata),
        .dmem_rdata(dmem_rdata));

    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    // pulse is one clock wide, so latch it rather than catch it in the act
    always @(posedge clk_sys)
    begin
        if (wdt_clear === 1'b1)
            wdt_seen <= 1'b1;
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp8

    task automatic chk_state(input logic [7:0] a, input logic c, input logic z);
        cmp8("acc", a, acc);
        cmp8("carry", {7'h00, c}, {7'h00, carry});
        cmp8("zero", {7'h00, z}, {7'h00, zero});
    endtask : chk_state

    task automatic chk_wr(input logic we, input logic [7:0] d);
        cmp8("write strobe", {7'h00, we}, {7'h00, dmem_we});
        if (we)
            cmp8("write data", d, dmem_wdata);
    endtask : chk_wr

    task automatic put(input logic [7:0] a, input op_t op, input logic [2:0] s,
                       input logic [7:0] arg);
        instr_t w;
        w = '{op, s, arg};
        i_mem.pmem[a] = w;
    endtask : put

    task automatic rst_on();
        @(posedge clk_sys);
        resetn   <= 1'b0;
        wake     <= 1'b0;
        wdt_seen <= 1'b0;
        for (int i = 0; i < 256; i++)
        begin
            i_mem.pmem[i] = 16'h0000;
            i_mem.dmem[i] = 8'h00;
        end
    endtask : rst_on

    task automatic rst_off();
        repeat (3) @(posedge clk_sys);
        resetn <= 1'b1;
    endtask : rst_off

    // exp 0: first instruction after reset or after wake, only its arrival is checked
    task automatic step(input int exp);
        int   n;
        logic extra_seen;
        n          = 0;
        extra_seen = 1'b0;
        do
        begin
            @(negedge clk_sys);
            n++;
            extra_seen = extra_seen | (extra_cycle === 1'b1);
        end
        while (instr_done !== 1'b1 && n < 40);
        if (exp > 0)
        begin
            cmp8("clocks per instruction", 8'(exp), 8'(n));
            cmp8("extra cycle", {7'h00, exp > 4}, {7'h00, extra_seen});
        end
        else
            cmp8("instruction done", 8'h01, {7'h00, instr_done});
    endtask : step

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_arith();
        rst_on();
        i_mem.dmem[8'h0A] = 8'h01;
        i_mem.dmem[8'h0B] = 8'h01;
        i_mem.dmem[8'h0C] = 8'h7F;
        put(8'h00, OP_MOVI, 3'h0, 8'hFF);
        put(8'h01, OP_ADD, 3'h1, 8'h0A);
        put(8'h02, OP_SUB, 3'h1, 8'h0B);
        put(8'h03, OP_INC, 3'h0, 8'h0C);
        put(8'h04, OP_DEC, 3'h1, 8'h0B);
        rst_off();
        step(0);
        step(4);
        chk_state(8'h00, 1'b1, 1'b1);
        step(4);
        chk_state(8'hFF, 1'b0, 1'b0);
        step(4);
        chk_wr(1'b1, 8'h80);
        cmp8("acc kept", 8'hFF, acc);
        step(4);
        chk_state(8'h00, 1'b0, 1'b1);
    endtask : t_arith

    task automatic t_logic();
        rst_on();
        i_mem.dmem[8'h14] = 8'hF0;
        i_mem.dmem[8'h15] = 8'hFF;
        put(8'h00, OP_MOVI, 3'h0, 8'h0F);
        put(8'h01, OP_AND, 3'h1, 8'h14);
        put(8'h02, OP_MOVI, 3'h0, 8'h0F);
        put(8'h03, OP_OR, 3'h1, 8'h14);
        put(8'h04, OP_XOR, 3'h1, 8'h14);
        put(8'h05, OP_INV, 3'h1, 8'h15);
        rst_off();
        step(0);
        step(4);
        chk_state(8'h00, 1'b0, 1'b1);
        step(4);
        cmp8("acc immediate", 8'h0F, acc);
        step(4);
        chk_state(8'hFF, 1'b0, 1'b0);
        step(4);
        chk_state(8'h0F, 1'b0, 1'b0);
        step(4);
        chk_state(8'h00, 1'b0, 1'b1);
    endtask : t_logic

    task automatic t_rotate();
        rst_on();
        i_mem.dmem[8'h1E] = 8'h81;
        put(8'h00, OP_RR, 3'h1, 8'h1E);
        put(8'h01, OP_RL, 3'h1, 8'h1E);
        put(8'h02, OP_RRC, 3'h1, 8'h1E);
        put(8'h03, OP_RLC, 3'h1, 8'h1E);
        put(8'h04, OP_MOVMA, 3'h0, 8'h1F);
        put(8'h05, OP_MOVM, 3'h1, 8'h1E);
        rst_off();
        step(0);
        chk_state(8'hC0, 1'b0, 1'b0);
        step(4);
        chk_state(8'h03, 1'b0, 1'b0);
        step(4);
        chk_state(8'h40, 1'b1, 1'b0);
        step(4);
        chk_state(8'h03, 1'b1, 1'b0);
        step(4);
        chk_wr(1'b1, 8'h03);
        cmp8("write address", 8'h1F, dmem_addr);
        step(4);
        cmp8("acc from memory", 8'h81, acc);
    endtask : t_rotate

    task automatic t_branch();
        rst_on();
        i_mem.dmem[8'h29] = 8'h08;
        put(8'h00, OP_CALL, 3'h0, 8'h10);
        put(8'h10, OP_RET, 3'h0, 8'h00);
        put(8'h01, OP_JUMP, 3'h0, 8'h20);
        put(8'h20, OP_SZ, 3'h0, 8'h28);
        put(8'h22, OP_SNZ, 3'h0, 8'h28);
        put(8'h23, OP_SZB, 3'h3, 8'h29);
        put(8'h24, OP_SNZB, 3'h3, 8'h29);
        put(8'h26, OP_CALL, 3'h0, 8'h30);
        put(8'h30, OP_INTERRUPT_EXIT, 3'h0, 8'h00);
        rst_off();
        step(0);
        cmp8("call target", 8'h10, pmem_addr);
        step(8);
        cmp8("return point", 8'h01, pmem_addr);
        step(8);
        cmp8("jump target", 8'h20, pmem_addr);
        step(8);
        cmp8("byte skip taken", 8'h22, pmem_addr);
        step(4);
        cmp8("byte no skip", 8'h23, pmem_addr);
        step(4);
        cmp8("bit no skip", 8'h24, pmem_addr);
        step(8);
        cmp8("bit skip taken", 8'h26, pmem_addr);
        step(8);
        step(8);
        cmp8("interrupt exit point", 8'h27, pmem_addr);
    endtask : t_branch

    task automatic t_pcl();
        rst_on();
        put(8'h00, OP_MOVI, 3'h0, 8'h08);
        put(8'h01, OP_MOVMA, 3'h0, PCL_ADDR);
        put(8'h08, OP_CLRM, 3'h0, PCL_ADDR);
        rst_off();
        step(0);
        step(8);
        cmp8("pcl move target", 8'h08, pmem_addr);
        chk_wr(1'b0, 8'h00);
        step(8);
        cmp8("pcl clear target", 8'h00, pmem_addr);
        chk_wr(1'b0, 8'h00);
    endtask : t_pcl

    task automatic t_bits_sys();
        rst_on();
        i_mem.dmem[8'h32] = 8'hA5;
        i_mem.dmem[8'h33] = 8'h80;
        i_mem.pmem[8'h80] = 16'h1234;
        put(8'h00, OP_BSET, 3'h1, 8'h32);
        put(8'h01, OP_BCLR, 3'h5, 8'h32);
        put(8'h02, OP_TBLRD, 3'h0, 8'h33);
        put(8'h03, OP_SYS, SYS_WDT_CLEAR, 8'h00);
        put(8'h04, OP_SYS, SYS_POWER_DOWN, 8'h00);
        put(8'h05, OP_MOVI, 3'h0, 8'h5A);
        rst_off();
        step(0);
        chk_wr(1'b1, 8'hA7);
        step(4);
        chk_wr(1'b1, 8'h87);
        step(8);
        cmp8("table data", 8'h34, acc);
        cmp8("no early watchdog clear", 8'h00, {7'h00, wdt_seen});
        step(4);
        cmp8("watchdog clear", 8'h01, {7'h00, wdt_clear});
        step(4);
        repeat (8) @(negedge clk_sys);
        cmp8("halted", 8'h01, {7'h00, halted});
        cmp8("acc while halted", 8'h34, acc);
        @(posedge clk_sys);
        wake <= 1'b1;
        step(0);
        cmp8("after wake", 8'h5A, acc);
        cmp8("awake", 8'h00, {7'h00, halted});
        @(posedge clk_sys);
        wake <= 1'b0;
    endtask : t_bits_sys

    task automatic test_done();
        $display("mismatches %0d, comparisons %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : test_done

    // whole run is about 220 clocks; the 100us limit is 4000 clocks, well over ten times that
    initial
    begin
        #100us;
        n_errors++;
        test_done();
    end

    initial
    begin
        resetn   = 1'b0;
        wake     = 1'b0;
        wdt_seen = 1'b0;
        t_arith();
        t_logic();
        t_rotate();
        t_branch();
        t_pcl();
        t_bits_sys();
        test_done();
    end
endmodule : mcu_instruction_timing_control_tb_top
